//--- gdm_cfg.svh
// Timing constants and fixed levels for the gate drive mode logic.
// Assumes a 40 MHz sys_clk; start, pulse and glitch counts derive from that rate, the rest are fixed cycles.
`ifndef GDM_CFG_SVH
`define GDM_CFG_SVH

`define GDM_CLK_HZ 40000000
`define GDM_FULL_START_US 40
`define GDM_PART_START_US 30
`define GDM_MIN_PULSE_NS 37
`define GDM_GLITCH_NS 5
`define GDM_MAX_FSW_HZ 1000000
// Least times round up to whole cycles
`define GDM_FULL_START_CYC \
  ((`GDM_FULL_START_US * (`GDM_CLK_HZ / 1000000)))
`define GDM_PART_START_CYC \
  ((`GDM_PART_START_US * (`GDM_CLK_HZ / 1000000)))
`define GDM_MIN_PULSE_CYC \
  ((`GDM_MIN_PULSE_NS * (`GDM_CLK_HZ / 1000000) + 999) / 1000)
`define GDM_GLITCH_CYC \
  (((`GDM_GLITCH_NS * (`GDM_CLK_HZ / 1000000) + 999) / 1000) < 1 ? 1 : \
   ((`GDM_GLITCH_NS * (`GDM_CLK_HZ / 1000000) + 999) / 1000))
`define GDM_NONOVL_CYC 2
`define GDM_BLANK_CYC 8
`define GDM_CFG_LOAD_CYC 4

`endif

//--- gdm_core.sv
// Gate drive mode logic: power states, three-level decode, gate timing.
// Assumes PWM and mode select arrive as decoded levels on sys_clk.
//
// Functional notes
// (RULE1) Supply lockout holds gates off; 40 us then power-ready.
// (RULE2) Supply valid, shutdown low: sleep with both gates off.
// (RULE3) Leaving sleep takes 30 us to power-ready.
// (RULE4) Fuse configuration loads while sleeping.
// (RULE5) Gates follow PWM only with supply valid and shutdown high.
// (RULE6) Fault output held low until power-ready.
// (RULE7) Mode low: forced rectification; mid PWM turns both off.
// (RULE8) Mode high, PWM mid: high off, low on through blanking.
// (RULE9) After blanking, low side turns off on zero current.
// (RULE10) Mode mid, PWM low: low on, blanking, then zero-current off.
// (RULE11) Mode mid: PWM mid both off; PWM high high side on.
// (RULE12) Open mode select resolves to mid through a divider.
// (RULE13) Controller wanting device zero detection uses mode high or open.
// (RULE14) Controller toggles high/low for CCM, mid for DCM.
// (RULE15) Zero before blanking end: low side stays on until end.
// (RULE16) Blanking ends first: low side waits for zero current.
// (RULE17) Mid to low starts blanking; early mid waits for expiry.
// (RULE18) Short high pulses stretched to minimum 37 ns.
// (RULE19) High pulses under 5 ns are ignored.
// (RULE20) Supports PWM switching up to 1 MHz.
// (RULE21) PWM and mode arrive as decoded synchronous levels.
// (RULE22) Dead time and blanking are cycle parameters; no overlap.
`timescale 1ns/1ps
`include "gdm_cfg.svh"
module gdm_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Three-level commands, already decoded
  input wire gdm_pkg::gdm_level_type pwm_level, // RULE21
  input wire gdm_pkg::gdm_level_type zero_cross_mode_select,
  // Asynchronous status pins
  input wire logic supply_low_lockout,
  input wire logic shutdown_bar_input,
  input wire logic zero_current_turnoff,
  // Fuse configuration word
  input wire logic [7:0] fuse_data,
  // Outputs
  output gdm_pkg::gdm_gates_type gates,
  output logic fault_out,
  output logic fault_oe_n,
  output logic power_ready,
  output logic [7:0] fuse_config
);
  import gdm_pkg::*;

  localparam int FULL_CYC = `GDM_FULL_START_CYC;
  localparam int PART_CYC = `GDM_PART_START_CYC;
  localparam int MINP_CYC = `GDM_MIN_PULSE_CYC;
  localparam int GLITCH_CYC = `GDM_GLITCH_CYC;
  localparam int NONOVL_CYC = `GDM_NONOVL_CYC;
  // Dead time plus blanking stays far inside a 1 MHz switching period
  localparam int BLANK_CYC = `GDM_BLANK_CYC; // RULE20

  // ****************************************
  // Input synchronisation
  // ****************************************
  gdm_status_type raw_status;
  gdm_status_type sync_status;

  assign raw_status.supply_ok = ~supply_low_lockout;
  assign raw_status.shutdown_bar = shutdown_bar_input;
  assign raw_status.zero_cross = zero_current_turnoff;

  gdm_sync u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .raw_in(raw_status),
    .sync_out(sync_status)
  );

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    gdm_power_type pwr;
    logic from_sleep;
    logic [11:0] start_cnt;
    logic cfg_done;
    logic [7:0] cfg;
    gdm_gate_type gt;
    logic [7:0] dead_cnt;
    logic [7:0] blank_cnt;
    logic [7:0] on_cnt;
    logic [7:0] hi_cnt;
    logic blank_done;
    gdm_gates_type g;
  } gdm_core_state_type;

  gdm_core_state_type s_reg;
  gdm_core_state_type s_next;

  function automatic logic [7:0] sat_dec(input logic [7:0] v);
    sat_dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  logic enabled;
  logic hi_cmd;
  logic ls_cmd;
  logic zcd_mode;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // Synced status gates the outputs at once, not a cycle after the state
    enabled = (s_reg.pwr == GDM_ST_RUN) && sync_status.supply_ok &&
              sync_status.shutdown_bar; // RULE5
    // High command counts only after it survives the glitch filter
    if (pwm_level == GDM_LVL_HIGH) begin
      s_next.hi_cnt = (s_reg.hi_cnt == 8'hff) ? 8'hff : s_reg.hi_cnt + 8'h01;
    end else begin
      s_next.hi_cnt = 8'h00;
    end
    hi_cmd = (pwm_level == GDM_LVL_HIGH) &&
             (s_reg.hi_cnt >= 8'(GLITCH_CYC - 1)); // RULE19
    // Which PWM levels demand the low side, by mode
    zcd_mode = 1'b0;
    ls_cmd = 1'b0;
    unique case (zero_cross_mode_select)
      GDM_LVL_LOW: begin
        ls_cmd = (pwm_level == GDM_LVL_LOW); // RULE7
      end
      GDM_LVL_HIGH: begin
        ls_cmd = (pwm_level != GDM_LVL_HIGH); // RULE8
        zcd_mode = (pwm_level == GDM_LVL_MID);
      end
      GDM_LVL_MID: begin
        // Open pin arrives as mid from the divider upstream
        ls_cmd = (pwm_level == GDM_LVL_LOW); // RULE10 RULE12
        zcd_mode = 1'b1;
      end
      default: begin
        ls_cmd = 1'b0;
      end
    endcase

    // Power sequencing
    unique case (s_reg.pwr)
      GDM_ST_OFF: begin
        s_next.start_cnt = 12'h000;
        if (sync_status.supply_ok) begin
          s_next.from_sleep = 1'b0;
          s_next.pwr = sync_status.shutdown_bar ? GDM_ST_START
                                                : GDM_ST_SLEEP;
        end
      end
      GDM_ST_SLEEP: begin
        s_next.from_sleep = 1'b1;
        s_next.start_cnt = 12'h000;
        if (!s_reg.cfg_done) begin
          s_next.cfg = fuse_data; // RULE4
          s_next.cfg_done = 1'b1;
        end
        if (!sync_status.supply_ok) begin
          s_next.pwr = GDM_ST_OFF;
        end else if (sync_status.shutdown_bar) begin
          s_next.pwr = GDM_ST_START;
        end
      end
      GDM_ST_START: begin
        s_next.start_cnt = s_reg.start_cnt + 12'h001;
        if (!sync_status.supply_ok) begin
          s_next.pwr = GDM_ST_OFF; // RULE1
        end else if (!sync_status.shutdown_bar) begin
          s_next.pwr = GDM_ST_SLEEP; // RULE2
        end else if ((s_reg.from_sleep &&
                      s_reg.start_cnt == 12'(PART_CYC - 1)) || // RULE3
                     (!s_reg.from_sleep &&
                      s_reg.start_cnt == 12'(FULL_CYC - 1))) begin // RULE1
          s_next.pwr = GDM_ST_RUN;
        end
      end
      GDM_ST_RUN: begin
        if (!sync_status.supply_ok) begin
          s_next.pwr = GDM_ST_OFF;
        end else if (!sync_status.shutdown_bar) begin
          s_next.pwr = GDM_ST_SLEEP;
        end
      end
      default: begin
        s_next.pwr = GDM_ST_OFF;
      end
    endcase

    // Gate sequencing; counters saturate at zero
    s_next.dead_cnt = sat_dec(s_reg.dead_cnt);
    s_next.on_cnt = sat_dec(s_reg.on_cnt);
    s_next.blank_cnt = sat_dec(s_reg.blank_cnt);
    unique case (s_reg.gt)
      GDM_GT_IDLE: begin
        if (hi_cmd) begin
          s_next.gt = GDM_GT_DEAD_HS;
          s_next.dead_cnt = 8'(NONOVL_CYC - 1);
        end else if (ls_cmd) begin
          s_next.gt = GDM_GT_DEAD_LS;
          s_next.dead_cnt = 8'(NONOVL_CYC - 1);
        end
      end
      GDM_GT_DEAD_HS: begin
        if (s_reg.dead_cnt == 8'h00) begin
          s_next.gt = GDM_GT_HS_ON;
          s_next.on_cnt = 8'(MINP_CYC - 1);
        end
      end
      GDM_GT_HS_ON: begin
        // Hold the high side until the minimum pulse is served
        if (!hi_cmd && s_reg.on_cnt == 8'h00) begin // RULE18
          s_next.gt = GDM_GT_DEAD_LS; // RULE22
          s_next.dead_cnt = 8'(NONOVL_CYC - 1);
        end
      end
      GDM_GT_DEAD_LS: begin
        if (hi_cmd) begin
          s_next.gt = GDM_GT_DEAD_HS;
        end else if (s_reg.dead_cnt == 8'h00) begin
          if (ls_cmd) begin
            s_next.gt = GDM_GT_LS_BLANK;
            s_next.blank_cnt = 8'(BLANK_CYC - 1);
          end else begin
            s_next.gt = GDM_GT_IDLE; // RULE7 RULE11
          end
        end
      end
      GDM_GT_LS_BLANK: begin
        if (hi_cmd) begin
          s_next.gt = GDM_GT_DEAD_HS;
          s_next.dead_cnt = 8'(NONOVL_CYC - 1);
        end else if (s_reg.blank_cnt == 8'h00) begin
          // Zero seen during blanking is ignored until expiry
          s_next.gt = GDM_GT_LS_ON; // RULE15 RULE17
        end
      end
      GDM_GT_LS_ON: begin
        if (hi_cmd) begin
          s_next.gt = GDM_GT_DEAD_HS;
          s_next.dead_cnt = 8'(NONOVL_CYC - 1);
        end else if (!ls_cmd && !zcd_mode) begin
          s_next.gt = GDM_GT_IDLE;
        end else if (zcd_mode || (zero_cross_mode_select == GDM_LVL_MID
                     && ls_cmd)) begin
          s_next.gt = GDM_GT_LS_WAITZ;
        end
      end
      GDM_GT_LS_WAITZ: begin
        if (hi_cmd) begin
          s_next.gt = GDM_GT_DEAD_HS;
          s_next.dead_cnt = 8'(NONOVL_CYC - 1);
        end else if (sync_status.zero_cross) begin
          s_next.gt = GDM_GT_IDLE; // RULE9 RULE16
        end else if (!ls_cmd) begin
          s_next.gt = GDM_GT_IDLE; // RULE11
        end
      end
      default: begin
        s_next.gt = GDM_GT_IDLE;
      end
    endcase
    if (!enabled) begin
      s_next.gt = GDM_GT_IDLE; // RULE2 RULE5
    end
    // A finished zero-current episode blocks re-entry until the command
    // moves on; a low command in mode high starts a fresh blanking
    if (s_next.gt == GDM_GT_IDLE && s_reg.gt == GDM_GT_LS_WAITZ) begin
      s_next.blank_done = 1'b1;
    end else if (!ls_cmd || (zero_cross_mode_select == GDM_LVL_HIGH &&
                 pwm_level == GDM_LVL_LOW)) begin
      s_next.blank_done = 1'b0; // RULE17
    end
    if (s_reg.gt == GDM_GT_IDLE && s_next.gt == GDM_GT_DEAD_LS &&
        s_reg.blank_done) begin
      s_next.gt = GDM_GT_IDLE; // RULE9
    end
    // Outputs registered; exclusive by construction
    s_next.g.high_side_gate = enabled && (s_next.gt == GDM_GT_HS_ON);
    s_next.g.low_side_gate = enabled && !s_next.g.high_side_gate &&
      ((s_next.gt == GDM_GT_LS_BLANK) || (s_next.gt == GDM_GT_LS_ON) ||
       (s_next.gt == GDM_GT_LS_WAITZ)); // RULE22
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign gates = s_reg.g;
  assign power_ready = (s_reg.pwr == GDM_ST_RUN);
  // Open-drain style: drive low until ready, then release
  assign fault_out = 1'b0;
  assign fault_oe_n = (s_reg.pwr == GDM_ST_RUN); // RULE6
  assign fuse_config = s_reg.cfg;

  // ****************************************
  // Assertions
  // ****************************************
  a_no_overlap: assert property ( // RULE22
    @(posedge sys_clk) disable iff (!arst_n)
    !(gates.high_side_gate && gates.low_side_gate))
    else $error("Both gates on together");

  a_off_not_ready: assert property ( // RULE5
    @(posedge sys_clk) disable iff (!arst_n)
    !power_ready |-> !gates.high_side_gate && !gates.low_side_gate)
    else $error("Gate on while not ready");

  a_fault_low: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!arst_n)
    !power_ready |-> !fault_oe_n)
    else $error("Fault pin released before ready");

  a_lockout_off: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!arst_n)
    !sync_status.supply_ok |=> !power_ready)
    else $error("Ready during lockout");

  a_sleep_off: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!arst_n)
    (sync_status.supply_ok && !sync_status.shutdown_bar) |=>
      !gates.high_side_gate && !gates.low_side_gate)
    else $error("Gate on in sleep");

  a_min_pulse: assert property ( // RULE18
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(gates.high_side_gate) |-> gates.high_side_gate[*2])
    else $error("High pulse shorter than minimum");

  a_blank_hold: assert property ( // RULE15
    @(posedge sys_clk) disable iff (!arst_n)
    (s_reg.gt == GDM_GT_LS_BLANK && !hi_cmd && enabled) |=>
      gates.low_side_gate)
    else $error("Low side dropped during blanking");

  a_zero_off: assert property ( // RULE9
    @(posedge sys_clk) disable iff (!arst_n)
    (s_reg.gt == GDM_GT_LS_WAITZ && sync_status.zero_cross) |=>
      !gates.low_side_gate)
    else $error("Low side not off at zero current");

  a_start_time: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(power_ready) |-> $past(s_reg.start_cnt) ==
      (s_reg.from_sleep ? 12'(PART_CYC - 1) : 12'(FULL_CYC - 1)))
    else $error("Ready came too early");
endmodule

//--- gdm_core_tb.sv
// Self-checking bench for the gate drive mode logic.
// Assumes the zero-current comparator is driven here, PWM by the model.
`timescale 1ns/1ps
module gdm_core_tb;
  import gdm_pkg::*;

  logic sys_clk;
  logic arst_n;
  logic supply_low_lockout;
  logic shutdown_bar_input;
  logic zero_current_turnoff;
  logic [7:0] fuse_data;
  gdm_level_type pwm_level;
  gdm_level_type mode_sel;
  gdm_gates_type gates;
  logic fault_out;
  logic fault_oe_n;
  logic power_ready;
  logic [7:0] fuse_config;
  int mismatches;
  int total_checks;
  int len;

  // Rows: mode, PWM, expected {high side, low side}; order matters
  // because mid PWM restarts the low side only once PWM has left mid after a zero-current off
  localparam logic [5:0] rows [9] = '{
    {GDM_LVL_LOW, GDM_LVL_HIGH, 2'b10}, {GDM_LVL_LOW, GDM_LVL_LOW, 2'b01},
    {GDM_LVL_LOW, GDM_LVL_MID, 2'b00}, {GDM_LVL_HIGH, GDM_LVL_HIGH, 2'b10},
    {GDM_LVL_HIGH, GDM_LVL_MID, 2'b01}, {GDM_LVL_HIGH, GDM_LVL_LOW, 2'b01},
    {GDM_LVL_MID, GDM_LVL_HIGH, 2'b10}, {GDM_LVL_MID, GDM_LVL_MID, 2'b00},
    {GDM_LVL_MID, GDM_LVL_LOW, 2'b01}};

  gdm_ctrl_model i_ctrl (
    .sys_clk(sys_clk),
    .pwm_level(pwm_level),
    .mode_sel(mode_sel)
  );

  gdm_core i_dut (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pwm_level(pwm_level),
    .zero_cross_mode_select(mode_sel),
    .supply_low_lockout(supply_low_lockout),
    .shutdown_bar_input(shutdown_bar_input),
    .zero_current_turnoff(zero_current_turnoff),
    .fuse_data(fuse_data),
    .gates(gates),
    .fault_out(fault_out),
    .fault_oe_n(fault_oe_n),
    .power_ready(power_ready),
    .fuse_config(fuse_config)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic sel(input bit hs);
    return hs ? gates.high_side_gate : gates.low_side_gate;
  endfunction

  // Waits up to 16 cycles for a gate to rise, then counts its width
  task automatic pulse_len(input bit hs, output int n);
    n = 0;
    for (int i = 0; i < 16 && sel(hs) !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    while (sel(hs) === 1'b1 && n < 64) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    while (power_ready !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  // Shoot-through and the ready indication are watched all run long
  always @(negedge sys_clk) begin
    if (arst_n === 1'b1) begin
      check(gates.high_side_gate & gates.low_side_gate, 1'b0);
      check({fault_out, fault_oe_n}, {1'b0, power_ready});
    end
  end

  initial begin
    #(25 * 20000);
    mismatches++;
    complete_run();
  end

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    arst_n = 1'b0;
    supply_low_lockout = 1'b1;
    shutdown_bar_input = 1'b1;
    zero_current_turnoff = 1'b0;
    fuse_data = 8'h3c;
    repeat (10) @(posedge sys_clk);
    #1 check({gates, fault_oe_n, power_ready, fuse_config}, 0);
    @(posedge sys_clk) arst_n <= 1'b1;
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_LOW, 8);
    check(gates, 2'b00);
    @(posedge sys_clk) supply_low_lockout <= 1'b0;
    #1 wait_ready(len);
    check(len >= 1600 && len <= 1610, 1'b1);
    for (int i = 0; i < 9; i++) begin
      i_ctrl.drive(gdm_level_type'(rows[i][3:2]),
                   gdm_level_type'(rows[i][5:4]), 12);
      check(gates, rows[i][1:0]);
    end
    // Full-rate switching at 1 MHz
    repeat (3) begin
      i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_LOW, 20);
      check(gates, 2'b10);
      i_ctrl.drive(GDM_LVL_LOW, GDM_LVL_LOW, 20);
      check(gates, 2'b01);
    end
    // One-cycle command: kept, and widened to the minimum pulse
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_LOW, 1);
    i_ctrl.drive(GDM_LVL_LOW, GDM_LVL_LOW, 1);
    pulse_len(1'b1, len);
    check(len >= 2 && len <= 4, 1'b1);
    // Zero current seen early: low side still waits out the blanking
    @(posedge sys_clk) zero_current_turnoff <= 1'b1;
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_HIGH, 12);
    i_ctrl.drive(GDM_LVL_MID, GDM_LVL_HIGH, 1);
    pulse_len(1'b0, len);
    check(len >= 8 && len <= 11, 1'b1);
    i_ctrl.drive(GDM_LVL_LOW, GDM_LVL_HIGH, 2);
    i_ctrl.drive(GDM_LVL_MID, GDM_LVL_HIGH, 1);
    pulse_len(1'b0, len);
    check(len >= 6 && len <= 11, 1'b1);
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_MID, 12);
    i_ctrl.drive(GDM_LVL_LOW, GDM_LVL_MID, 1);
    pulse_len(1'b0, len);
    check(len >= 8 && len <= 11, 1'b1);
    check(gates, 2'b00);
    // Blanking over first: low side holds until zero current
    @(posedge sys_clk) zero_current_turnoff <= 1'b0;
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_HIGH, 12);
    i_ctrl.drive(GDM_LVL_MID, GDM_LVL_HIGH, 24);
    check(gates, 2'b01);
    @(posedge sys_clk) zero_current_turnoff <= 1'b1;
    #1 pulse_len(1'b0, len);
    check(len >= 1 && len <= 4, 1'b1);
    // Sleep, fuse load, and the shorter restart
    @(posedge sys_clk);
    shutdown_bar_input <= 1'b0;
    fuse_data <= 8'ha5;
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_LOW, 20);
    check({gates, power_ready}, 3'b000);
    check(fuse_config, 8'ha5);
    @(posedge sys_clk) shutdown_bar_input <= 1'b1;
    #1 wait_ready(len);
    check(len >= 1200 && len <= 1210, 1'b1);
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_LOW, 8);
    check(gates, 2'b10);
    @(posedge sys_clk) supply_low_lockout <= 1'b1;
    i_ctrl.drive(GDM_LVL_HIGH, GDM_LVL_LOW, 8);
    check({gates, power_ready}, 3'b000);
    @(posedge sys_clk) arst_n <= 1'b0;
    #1 check({gates, fault_oe_n, power_ready, fuse_config}, 0);
    complete_run();
  end
endmodule

//--- gdm_ctrl_model.sv
// Partner model: a three-level PWM controller feeding the gate logic.
// Assumes the bench calls its task from a single process.
`timescale 1ns/1ps
module gdm_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Decoded commands towards the gate logic
  output gdm_pkg::gdm_level_type pwm_level,
  output gdm_pkg::gdm_level_type mode_sel
);
  import gdm_pkg::*;

  // ************************************************************
  // Command driver
  // ************************************************************
  initial begin
    pwm_level = GDM_LVL_MID;
    mode_sel = GDM_LVL_MID;
  end

  // Holds one command for whole cycles; returns just after an edge so
  // the caller can sample settled outputs
  task automatic drive(input gdm_level_type lvl, input gdm_level_type mode,
                       input int cycles);
    @(posedge sys_clk);
    pwm_level <= lvl;
    mode_sel <= mode;
    repeat (cycles - 1) @(posedge sys_clk);
    #1;
  endtask
endmodule

//--- gdm_pkg.sv
// Types for the gate drive mode logic.
// Assumes the three-level inputs are decoded by comparators upstream.
package gdm_pkg;

  typedef enum logic [1:0] {
    GDM_LVL_LOW,
    GDM_LVL_MID,
    GDM_LVL_HIGH
  } gdm_level_type;

  typedef enum logic [2:0] {
    GDM_ST_OFF,
    GDM_ST_SLEEP,
    GDM_ST_START,
    GDM_ST_RUN
  } gdm_power_type;

  typedef enum logic [2:0] {
    GDM_GT_IDLE,
    GDM_GT_HS_ON,
    GDM_GT_DEAD_LS,
    GDM_GT_LS_ON,
    GDM_GT_LS_BLANK,
    GDM_GT_LS_WAITZ,
    GDM_GT_DEAD_HS
  } gdm_gate_type;

  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
  } gdm_gates_type;

  typedef struct packed {
    logic supply_ok;
    logic shutdown_bar;
    logic zero_cross;
  } gdm_status_type;

endpackage

//--- gdm_sync.sv
// Two-flop synchroniser for the asynchronous status inputs.
// Assumes inputs come straight from pins or analog comparators.
`timescale 1ns/1ps
module gdm_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Raw and synchronised status
  input wire gdm_pkg::gdm_status_type raw_in,
  output gdm_pkg::gdm_status_type sync_out
);
  import gdm_pkg::*;

  typedef struct packed {
    gdm_status_type meta;
    gdm_status_type sync;
  } gdm_sync_state_type;

  gdm_sync_state_type state_reg;
  gdm_sync_state_type state_next;

  always_comb begin
    state_next.meta = raw_in;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.sync;
endmodule
